// file: core/adc_pkt_pkg.sv
// Constants shared by the sample packetizer and its FIFO
package adc_pkt_pkg;

    // ------------
    // Register map
    // ------------
    localparam logic [31:0] ADC_GENERAL_CONTROL_OFS = 32'h0000_0020;

    // ------------
    // Field positions in adc_general_control
    // ------------
    localparam int ENABLE_BIT = 0;
    localparam int CAL_SEL_BIT = 1;
    localparam int SPP_LSB = 8;
    localparam int SPP_MSB = 15;
    localparam int WIDTH_LSB = 16;
    localparam int WIDTH_MSB = 17;
    localparam int DROPPED_BIT = 24;

    // ------------
    // Reset values
    // ------------
    localparam logic ENABLE_RST = 1'h0;
    localparam logic CAL_SEL_RST = 1'h0;
    localparam logic [7:0] SPP_RST = 8'h01;
    localparam logic [1:0] WIDTH_RST = 2'h1;
    localparam logic DROPPED_RST = 1'h1;

    // ------------
    // Sample width encodings
    // ------------
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h3;

    // ------------
    // Timing and sizes
    // ------------
    localparam logic [2:0] CAL_PULSES = 3'h6;
    localparam int RESULT_W = 12;
    localparam int TOKEN_W = 9;
    localparam int FIFO_DEPTH = 8;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

endpackage : adc_pkt_pkg

// file: core/byte_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    // ------------
    // Storage and pointers
    // ------------
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count
    assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Write side
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_ptr_reg <= '0;
        end
        else if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                          : wr_ptr_reg + AW'(1);
        end
    end

    // Read side
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rd_ptr_reg <= '0;
        end
        else if (pop)
        begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                          : rd_ptr_reg + AW'(1);
        end
    end

    // Occupancy
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            count_reg <= '0;
        end
        else if (push && !pop)
        begin
            count_reg <= count_reg + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            count_reg <= count_reg - (AW+1)'(1);
        end
    end

endmodule : byte_fifo

`default_nettype wire

// file: core/adc_sample_packetizer_control.sv
// Converter control, sample packetizer and AHB-Lite register slave
//
// What this block does
// - Bit 24 flags lost samples, read clears
// - Bits 17:16 pick width, left-aligned, 2 reserved
// - Width 0: one byte, top eight bits
// - Width 1: sixteen bits, four low zeros, MSB first
// - Width 3: 32-bit word, twenty low zeros
// - Bits 15:8 give samples per packet
// - Zero: packet ends only on register access
// - Bit 1 selects internal calibration reference
// - While enabled, writes change only the enable bit
// - First six pulses after enable only calibrate
// - Seventh and later pulses deliver samples
// - Every enable rising edge restarts calibration
// - Reset: width 1, count 1, flag 1
`timescale 1ns/1ps
`default_nettype none

module adc_sample_packetizer_control (
    input wire logic clk_i,
    input wire logic arst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Trigger pin and converter
    input wire logic trigger_i,
    output logic conv_enable_o,
    output logic cal_sel_o,
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    // Channel end stream
    output logic [7:0] ch_data_o,
    output logic ch_end_o,
    output logic ch_valid_o,
    input wire logic ch_ready_i
);

    // ------------
    // Types and helpers
    // ------------
    typedef enum logic [1:0] {
        SER_IDLE,
        SER_DATA,
        SER_TERM
    } ser_state_t;

    // Bytes per sample for a width code; reserved code acts as 16-bit
    function automatic logic [2:0] bytes_for(input logic [1:0] code);
        logic [2:0] n;
        n = 3'h2;
        if (code == adc_pkt_pkg::WIDTH_8)
        begin
            n = 3'h1;
        end
        else if (code == adc_pkt_pkg::WIDTH_32)
        begin
            n = 3'h4;
        end
        return n;
    endfunction : bytes_for

    // ------------
    // Configuration and status state
    // ------------
    logic enable_reg; // Converter running
    logic cal_sel_reg; // Internal reference selected
    logic [7:0] spp_reg; // Samples per packet, zero means open
    logic [1:0] width_reg; // Sample width code
    logic dropped_reg; // Sticky lost-sample flag

    // ------------
    // Bus phase state
    // ------------
    logic wr_pend_reg; // Write data phase in progress
    logic hready_reg; // Bus ready, high once out of reset
    logic [31:0] rdata_reg; // Read data for the current data phase
    logic addr_take; // Valid address phase this cycle
    logic hit; // Address phase hits the control register
    logic reg_access; // Any access to the control register
    logic rd_clear; // Read that clears the dropped flag
    logic [31:0] ctrl_view; // Current register image

    // ------------
    // Trigger and converter state
    // ------------
    logic trig_meta_reg; // First synchroniser stage
    logic trig_sync_reg; // Second synchroniser stage
    logic trig_prev_reg; // Delayed copy for edge detect
    logic trig_rise;
    logic enable_prev_reg; // For enable rising edge
    logic [2:0] cal_left_reg; // Calibration pulses still owed
    logic conv_is_cal_reg; // Pending conversion only calibrates
    logic conv_start_reg;
    logic sample_done; // A delivering sample has finished
    logic sample_drop; // That sample cannot be taken

    // ------------
    // Serializer and packet state
    // ------------
    ser_state_t state_reg;
    logic [31:0] shift_reg; // Left-aligned sample, top byte next
    logic [2:0] bytes_left_reg; // Bytes of the sample still to push
    logic [7:0] pkt_count_reg; // Samples placed in the open packet
    logic term_req_reg; // Register access asked for a terminator
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [8:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [8:0] fifo_out_data;
    logic push;
    logic out_valid_reg;
    logic [8:0] out_data_reg;

    // ------------
    // AHB-Lite decode
    // ------------
    assign addr_take = hsel_i && hready_i
                       && (htrans_i == adc_pkt_pkg::HTRANS_NONSEQ);
    assign hit = haddr_i == adc_pkt_pkg::ADC_GENERAL_CONTROL_OFS;
    assign reg_access = addr_take && hit;
    assign rd_clear = reg_access && !hwrite_i;

    // Register image; reserved bits read as zero
    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[adc_pkt_pkg::ENABLE_BIT] = enable_reg;
        ctrl_view[adc_pkt_pkg::CAL_SEL_BIT] = cal_sel_reg;
        ctrl_view[adc_pkt_pkg::SPP_MSB:adc_pkt_pkg::SPP_LSB] = spp_reg;
        ctrl_view[adc_pkt_pkg::WIDTH_MSB:adc_pkt_pkg::WIDTH_LSB] =
            width_reg;
        ctrl_view[adc_pkt_pkg::DROPPED_BIT] = dropped_reg;
    end

    // Read data is captured at the address phase so it comes from a flop
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_reg <= '0;
        end
        else if (addr_take)
        begin
            // Unmapped addresses read as zero
            rdata_reg <= (hit && !hwrite_i) ? ctrl_view : '0;
        end
    end

    // Remember a pending write until its data phase
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_pend_reg <= 1'b0;
            hready_reg <= 1'b0;
        end
        else
        begin
            // Zero wait states once out of reset
            hready_reg <= 1'b1;
            if (hready_i)
            begin
                wr_pend_reg <= reg_access && hwrite_i;
            end
        end
    end

    // Ready from a flop and an OKAY answer for every transfer
    assign hrdata_o = rdata_reg;
    assign hreadyout_o = hready_reg;
    assign hresp_o = adc_pkt_pkg::HRESP_OKAY;

    // ------------
    // Configuration writes
    // ------------
    // Enable stays writable so software can stop a running converter
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            enable_reg <= adc_pkt_pkg::ENABLE_RST;
            cal_sel_reg <= adc_pkt_pkg::CAL_SEL_RST;
            spp_reg <= adc_pkt_pkg::SPP_RST;
            width_reg <= adc_pkt_pkg::WIDTH_RST;
        end
        else if (wr_pend_reg)
        begin
            enable_reg <= hwdata_i[adc_pkt_pkg::ENABLE_BIT];
            if (!enable_reg)
            begin
                cal_sel_reg <= hwdata_i[adc_pkt_pkg::CAL_SEL_BIT];
                spp_reg <= hwdata_i[adc_pkt_pkg::SPP_MSB:
                                    adc_pkt_pkg::SPP_LSB];
                width_reg <= hwdata_i[adc_pkt_pkg::WIDTH_MSB:
                                      adc_pkt_pkg::WIDTH_LSB];
            end
        end
    end

    // Sticky flag: a new drop wins over the read that clears it
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dropped_reg <= adc_pkt_pkg::DROPPED_RST;
        end
        else if (sample_drop)
        begin
            dropped_reg <= 1'b1;
        end
        else if (rd_clear)
        begin
            dropped_reg <= 1'b0;
        end
    end

    assign conv_enable_o = enable_reg;
    assign cal_sel_o = cal_sel_reg;

    // ------------
    // Trigger synchroniser and calibration phase
    // ------------
    // The pin is asynchronous; only the second stage feeds logic
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
        end
        else
        begin
            trig_meta_reg <= trigger_i;
            trig_sync_reg <= trig_meta_reg;
            trig_prev_reg <= trig_sync_reg;
        end
    end

    assign trig_rise = trig_sync_reg && !trig_prev_reg;

    // Calibration countdown and start pulse to the converter
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            enable_prev_reg <= 1'b0;
            cal_left_reg <= adc_pkt_pkg::CAL_PULSES;
            conv_is_cal_reg <= 1'b0;
            conv_start_reg <= 1'b0;
        end
        else
        begin
            enable_prev_reg <= enable_reg;
            conv_start_reg <= trig_rise && enable_reg;
            if (enable_reg && !enable_prev_reg)
            begin
                cal_left_reg <= adc_pkt_pkg::CAL_PULSES;
            end
            else if (trig_rise && enable_reg)
            begin
                conv_is_cal_reg <= (cal_left_reg != 3'h0);
                if (cal_left_reg != 3'h0)
                begin
                    cal_left_reg <= cal_left_reg - 3'h1;
                end
            end
        end
    end

    assign conv_start_o = conv_start_reg;

    assign sample_done = conv_done_i && enable_reg && !conv_is_cal_reg;
    assign sample_drop = sample_done && (state_reg != SER_IDLE);

    // ------------
    // Serializer into the FIFO
    // ------------
    // Token bit 8 marks a packet terminator; bits 7:0 carry data
    assign fifo_in_valid = (state_reg != SER_IDLE);
    assign fifo_in_data = (state_reg == SER_TERM) ? {1'b1, 8'h00}
                          : {1'b0, shift_reg[31:24]};
    assign push = fifo_in_valid && fifo_in_ready;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg <= SER_IDLE;
            shift_reg <= '0;
            bytes_left_reg <= 3'h0;
            pkt_count_reg <= 8'h00;
        end
        else
        begin
            unique case (state_reg)
                SER_IDLE:
                begin
                    if (sample_done)
                    begin
                        shift_reg <= {conv_data_i, 20'h0_0000};
                        bytes_left_reg <= bytes_for(width_reg);
                        state_reg <= SER_DATA;
                    end
                    else if (term_req_reg && pkt_count_reg != 8'h00)
                    begin
                        state_reg <= SER_TERM;
                    end
                end
                SER_DATA:
                begin
                    if (push)
                    begin
                        shift_reg <= {shift_reg[23:0], 8'h00};
                        bytes_left_reg <= bytes_left_reg - 3'h1;
                        if (bytes_left_reg == 3'h1)
                        begin
                            pkt_count_reg <= pkt_count_reg + 8'h01;
                            if (spp_reg != 8'h00
                                && pkt_count_reg + 8'h01 == spp_reg)
                            begin
                                state_reg <= SER_TERM;
                            end
                            else
                            begin
                                state_reg <= SER_IDLE;
                            end
                        end
                    end
                end
                SER_TERM:
                begin
                    if (push)
                    begin
                        pkt_count_reg <= 8'h00;
                        state_reg <= SER_IDLE;
                    end
                end
            endcase
        end
    end

    // A register access ends the open packet once the sample finishes
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            term_req_reg <= 1'b0;
        end
        else if (reg_access)
        begin
            term_req_reg <= 1'b1;
        end
        else if (state_reg == SER_TERM || (state_reg == SER_IDLE
                 && !sample_done && pkt_count_reg == 8'h00))
        begin
            term_req_reg <= 1'b0;
        end
    end

    // ------------
    // FIFO and output register
    // ------------
    // Eight tokens absorb channel stalls before samples start dropping
    byte_fifo #(
        .WIDTH(adc_pkt_pkg::TOKEN_W),
        .DEPTH(adc_pkt_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // Refill the output stage when empty or being consumed
    assign fifo_out_ready = !out_valid_reg || ch_ready_i;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end
        else if (fifo_out_ready)
        begin
            out_valid_reg <= fifo_out_valid;
            out_data_reg <= fifo_out_data;
        end
    end

    assign ch_valid_o = out_valid_reg;
    assign ch_data_o = out_data_reg[7:0];
    assign ch_end_o = out_data_reg[8];

endmodule : adc_sample_packetizer_control

`default_nettype wire

// file: verification/adc_sample_packetizer_control_chk.sv
// Port assertions of the sample packetizer
`timescale 1ns/1ps
`default_nettype none
module adc_sample_packetizer_control_chk (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic trigger_i,
    input wire logic conv_enable_o,
    input wire logic cal_sel_o,
    input wire logic conv_start_o,
    input wire logic [7:0] ch_data_o,
    input wire logic ch_end_o,
    input wire logic ch_valid_o,
    input wire logic ch_ready_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ------------
    // Bus phases
    // ------------
    // Accepted address phase of a write to the control word
    sequence s_wr;
        hsel_i && hready_i && htrans_i == 2'h2 && hwrite_i &&
            haddr_i == 32'h0000_0020;
    endsequence
    // Accepted read of an unmapped address
    sequence s_rd_hole;
        hsel_i && hready_i && htrans_i == 2'h2 && !hwrite_i &&
            haddr_i != 32'h0000_0020;
    endsequence
    // Pin edge seen while the converter is on
    sequence s_trig;
        $rose(trigger_i) && conv_enable_o;
    endsequence
    // ------------
    // Assertions
    // ------------
    AST_OKAY: assert property (hresp_o == 1'b0)
        else $error("slave answered with an error");
    AST_ZERO_WAIT: assert property ($past(arst_n_i) |-> hreadyout_o)
        else $error("slave inserted a wait state");
    AST_EN_WRITE: assert property (
        s_wr ##1 1'b1 |=> conv_enable_o == $past(hwdata_i[0]))
        else $error("enable did not follow the write");
    AST_CAL_FROZEN: assert property (
        conv_enable_o && $past(conv_enable_o) |-> $stable(cal_sel_o))
        else $error("reference select moved while enabled");
    AST_HOLE_ZERO: assert property (s_rd_hole |=> hrdata_o == 32'h0)
        else $error("unmapped read returned data");
    AST_START_LAT: assert property (s_trig |-> ##[2:4] conv_start_o)
        else $error("trigger did not start a conversion");
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("conversion start longer than one cycle");
    AST_IDLE_NO_START: assert property (
        !conv_enable_o [*4] |-> !conv_start_o)
        else $error("conversion started while disabled");
    AST_HOLD: assert property (ch_valid_o && !ch_ready_i |=>
        ch_valid_o && $stable(ch_data_o) && $stable(ch_end_o))
        else $error("channel token changed before it was taken");
    AST_END_ZERO: assert property (
        ch_valid_o && ch_end_o |-> ch_data_o == 8'h00)
        else $error("terminator carried data");
endmodule : adc_sample_packetizer_control_chk
`default_nettype wire

// file: verification/ch_end_model.sv
// Channel end model that takes sample tokens
`timescale 1ns/1ps
`default_nettype none
module ch_end_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] ch_data_i,
    input wire logic ch_end_i,
    input wire logic ch_valid_i,
    input wire logic slow_i,
    input wire logic hold_i,
    output logic ch_ready_o
);
    // Tokens taken, end flag above the byte
    logic [8:0] got_q[$];
    // ------------
    // Readiness: random stalls when slow, none taken on hold
    // ------------
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ch_ready_o <= 1'b0;
        else
            ch_ready_o <= !hold_i && (!slow_i || $urandom_range(1) == 1);
    end
    // Take one token on each handshake
    always @(posedge clk_i)
    begin
        if (arst_n_i && ch_valid_i && ch_ready_o)
            got_q.push_back({ch_end_i, ch_data_i});
    end
endmodule : ch_end_model
`default_nettype wire

// file: verification/adc_sample_packetizer_control_tb_top.sv
// Self-checking bench of the sample packetizer
`timescale 1ns/1ps
`default_nettype none
module adc_sample_packetizer_control_tb_top;
    logic clk_i, arst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic trigger_i, conv_enable_o, cal_sel_o, conv_start_o, conv_done_i;
    logic [11:0] conv_data_i, d;
    logic [7:0] ch_data_o, n;
    logic ch_end_o, ch_valid_o, ch_ready_i, slow, hold;
    logic [1:0] w;
    logic [1:0] wl[3] = '{2'h0, 2'h1, 2'h3};
    logic [8:0] exp_q[$];
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;

    adc_sample_packetizer_control i_adc_sample_packetizer_control (
        .clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
        .hreadyout_o, .hresp_o, .trigger_i, .conv_enable_o, .cal_sel_o,
        .conv_start_o, .conv_done_i, .conv_data_i, .ch_data_o,
        .ch_end_o, .ch_valid_o, .ch_ready_i);
    ch_end_model i_ch_end_model (.clk_i, .arst_n_i,
        .ch_data_i(ch_data_o), .ch_end_i(ch_end_o), .ch_valid_i(ch_valid_o),
        .slow_i(slow), .hold_i(hold), .ch_ready_o(ch_ready_i));

    // ------------
    // Clock and hang guard
    // ------------
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // A run far past its expected length counts as failed
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    // ------------
    // Helpers
    // ------------
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : check
    // Control word image from its fields
    function automatic logic [31:0] regv(input logic f, input logic [1:0] ww,
        input logic [7:0] nn, input logic c, input logic e);
        return {7'h0, f, 6'h0, ww, nn, 6'h0, c, e};
    endfunction : regv
    // One single transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [31:0] a, wd);
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= wr;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask : ahb
    // Bytes of one left-aligned sample, most significant first
    function automatic void exp_sample(input logic [1:0] ww, logic [11:0] dd);
        logic [31:0] s;
        s = {dd, 20'h0};
        for (int b = 0; b < (ww == 2'h0 ? 1 : ww == 2'h1 ? 2 : 4); b++)
            exp_q.push_back({1'b0, s[31-8*b -: 8]});
    endfunction : exp_sample
    // Pin pulse, then the converter answers with dd
    task automatic sample(input logic [11:0] dd, input logic drain);
        int k;
        trigger_i <= 1'b1;
        k = 0;
        while (conv_start_o !== 1'b1 && k < 20)
        begin
            @(posedge clk_i);
            k++;
        end
        if (k == 20)
            check("conversion start", 32'h1, 32'h0);
        trigger_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        conv_done_i <= 1'b1;
        conv_data_i <= dd;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        conv_data_i <= ~dd;
        // Draining avoids overlapping samples, which would be dropped
        repeat (drain ? 60 : 1) @(posedge clk_i);
    endtask : sample
    task automatic cmp_stream();
        repeat (20) @(posedge clk_i);
        check("token count", 32'(exp_q.size()),
            32'(i_ch_end_model.got_q.size()));
        foreach (exp_q[i])
            if (i < i_ch_end_model.got_q.size())
                check("token", 32'(exp_q[i]), 32'(i_ch_end_model.got_q[i]));
        exp_q.delete();
        i_ch_end_model.got_q.delete();
    endtask : cmp_stream
    // Disable, set fields, enable, run the calibration pulses
    task automatic setup(input logic [1:0] ww, input logic [7:0] nn);
        ahb(1'b1, 32'h20, 32'h0);
        ahb(1'b1, 32'h20, regv(1'b0, ww, nn, 1'b0, 1'b0));
        ahb(1'b1, 32'h20, regv(1'b0, ww, nn, 1'b0, 1'b1));
        repeat (6) sample(12'($urandom), 1'b1);
        cmp_stream();
    endtask : setup

    // ------------
    // Main sequence
    // ------------
    initial
    begin
        void'($urandom(24));
        {hsel_i, hwrite_i, trigger_i, conv_done_i, slow, hold} = 6'h20;
        {haddr_i, hwdata_i, htrans_i, conv_data_i} = '0;
        hsize_i = 3'h2;
        arst_n_i = 1'b0;
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        ahb(1'b0, 32'h20, 32'h0);
        check("reset value", regv(1'b1, 2'h1, 8'h01, 1'b0, 1'b0), rd);
        ahb(1'b0, 32'h20, 32'h0);
        check("flag after read", regv(1'b0, 2'h1, 8'h01, 1'b0, 1'b0), rd);
        ahb(1'b0, 32'h24, 32'h0);
        check("unmapped read", 32'h0, rd);
        ahb(1'b1, 32'h20, regv(1'b0, 2'h1, 8'h01, 1'b1, 1'b0));
        @(posedge clk_i);
        check("reference select", 32'h1, {31'h0, cal_sel_o});
        // Every width, packet sizes one to three
        foreach (wl[i])
        begin
            w = wl[i];
            n = 8'(i + 1);
            slow <= i[0];
            setup(w, n);
            for (int s = 0; s < 2 * n; s++)
            begin
                d = 12'($urandom);
                sample(d, 1'b1);
                exp_sample(w, d);
                if ((s + 1) % n == 0)
                    exp_q.push_back(9'h100);
            end
            cmp_stream();
            ahb(1'b1, 32'h20, regv(1'b0, w ^ 2'h3, 8'h05, 1'b1, 1'b1));
            ahb(1'b0, 32'h20, 32'h0);
            check("frozen fields", regv(1'b0, w, n, 1'b0, 1'b1), rd);
        end
        // Open packet closed only by a register access
        setup(2'h0, 8'h00);
        repeat (2)
        begin
            d = 12'($urandom);
            sample(d, 1'b1);
            exp_sample(2'h0, d);
        end
        cmp_stream();
        ahb(1'b0, 32'h20, 32'h0);
        exp_q.push_back(9'h100);
        cmp_stream();
        // Stalled channel end forces lost samples
        setup(2'h3, 8'h01);
        hold <= 1'b1;
        repeat (4) sample(12'($urandom), 1'b0);
        ahb(1'b0, 32'h20, 32'h0);
        check("dropped flag", 32'h1, {31'h0, rd[24]});
        hold <= 1'b0;
        repeat (300) @(posedge clk_i);
        i_ch_end_model.got_q.delete();
        report_and_stop();
    end
endmodule : adc_sample_packetizer_control_tb_top

bind adc_sample_packetizer_control adc_sample_packetizer_control_chk
    i_adc_sample_packetizer_control_chk (.clk_i, .arst_n_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o,
    .hreadyout_o, .hresp_o, .trigger_i, .conv_enable_o, .cal_sel_o,
    .conv_start_o, .ch_data_o, .ch_end_o, .ch_valid_o, .ch_ready_i);
`default_nettype wire
